// ==== hw/vcf_pkg.sv ====
// Package: command codes, field layout, reset values and timing of the vout config block
package vcf_pkg;
  localparam logic [6:0] BUS_ADDR = 7'h2a;
  localparam logic [7:0] CMD_CLEAR_FAULTS = 8'h03;
  localparam logic [7:0] CMD_CEILING = 8'h24;
  localparam logic [7:0] CMD_MARGIN_HIGH = 8'h25;
  localparam logic [7:0] CMD_MARGIN_LOW = 8'h26;
  localparam logic [7:0] CMD_RAMP_RATE = 8'h27;
  localparam logic [7:0] CMD_LOAD_LINE = 8'h28;
  localparam logic [7:0] CMD_SWITCH_FREQ = 8'h33;
  localparam logic [7:0] CMD_PHASE_GROUP = 8'h37;
  localparam logic [7:0] CMD_OV_THRESH = 8'h40;
  localparam logic [7:0] CMD_OV_REACTION = 8'h41;
  localparam logic [7:0] CMD_UV_THRESH = 8'h44;
  localparam logic [7:0] CMD_FAULT_STATUS = 8'h7a;
  localparam int REACT_MODE_LO = 6;
  localparam int RETRY_CNT_LO = 3;
  localparam int RETRY_TIME_LO = 0;
  localparam int RAILS_LO = 4;
  localparam int RAIL_POS_LO = 0;
  localparam int RATE_EXP_LO = 11;
  localparam int STAT_OV_BIT = 7;
  localparam int STAT_UV_BIT = 4;
  localparam logic [1:0] REACT_DISABLE_RETRY = 2'h2;
  localparam logic [2:0] RETRY_NONE = 3'h0;
  localparam logic [2:0] RETRY_FOREVER = 3'h7;
  localparam logic [1:0] MARGIN_HIGH_SEL = 2'h1;
  localparam logic [1:0] MARGIN_LOW_SEL = 2'h2;
  localparam logic [1:0] LEN_SEND = 2'h0;
  localparam logic [1:0] LEN_BYTE = 2'h1;
  localparam logic [1:0] LEN_WORD = 2'h2;
  localparam logic [15:0] RST_WORD = 16'h0000;
  localparam logic [15:0] RST_SWITCH_FREQ = 16'h00c8;
  localparam logic [7:0] RST_OV_REACTION = 8'h80;
  localparam logic [9:0] FREQ_MIN_KHZ = 10'h0c8;
  localparam logic [9:0] FREQ_MAX_KHZ = 10'h280;
  localparam int CEIL_PCT = 115;
  localparam int PCT_FULL = 100;
  localparam int CLK_HZ = 50_000_000;
  localparam int MS_PER_S = 1000;
  localparam int CYC_PER_MS = CLK_HZ / MS_PER_S;
  localparam int RETRY_STEP_MS = 35;
  typedef enum logic [1:0] {FS_OFF, FS_RUN, FS_WAIT, FS_LATCH} vcf_fault_state_t;
  typedef enum logic [2:0] {BS_IDLE, BS_RX, BS_RXACK, BS_STRETCH, BS_TX, BS_TXACK} vcf_bus_state_t;
endpackage

// ==== hw/vcf_bus_slave.sv ====
// Management-bus slave on the link clock: byte framing, ack, stretch
`timescale 1ns/100ps
`default_nettype none
module vcf_bus_slave (
  input wire logic link_clk_i,
  input wire logic link_rstn_i,
  input wire logic scl_i,
  input wire logic sda_i,
  output logic scl_oe_o,
  output logic sda_oe_o,
  output logic wr_tgl_o,
  output logic [7:0] wr_cmd_o,
  output logic [15:0] wr_data_o,
  output logic [1:0] wr_len_o,
  output logic rd_req_tgl_o,
  input wire logic rd_ack_tgl_i,
  input wire logic [15:0] rd_data_i
);
  import vcf_pkg::*;
  vcf_bus_state_t state;
  logic scl_s1, scl_s2, scl_d, sda_s1, sda_s2, sda_d, ack_s1, ack_s2, ack_d;
  logic [7:0] sh;
  logic [3:0] bitcnt;
  logic [2:0] idx;
  logic rw, host_ack, tx_hi, rd_ready;
  logic [15:0] rd_word;
  wire rise = scl_s2 & ~scl_d;
  wire fall = ~scl_s2 & scl_d;
  wire start_c = scl_s2 & scl_d & sda_d & ~sda_s2;
  wire stop_c = scl_s2 & scl_d & ~sda_d & sda_s2;
  wire ack_evt = ack_s2 ^ ack_d;
  wire rx_ack = (idx != 3'h0) | (sh[7:1] == BUS_ADDR);
  wire [7:0] tx_byte = tx_hi ? rd_word[15:8] : rd_word[7:0];

  always_ff @(posedge link_clk_i) begin
    {scl_s1, scl_s2, scl_d} <= {scl_i, scl_s1, scl_s2};
    {sda_s1, sda_s2, sda_d} <= {sda_i, sda_s1, sda_s2};
    {ack_s1, ack_s2, ack_d} <= {rd_ack_tgl_i, ack_s1, ack_s2};
  end

  always_ff @(posedge link_clk_i) begin
    if (!link_rstn_i) begin
      state <= BS_IDLE;
      {scl_oe_o, sda_oe_o, wr_tgl_o, rd_req_tgl_o, rw, host_ack, tx_hi, rd_ready} <= 8'h00;
      {sh, bitcnt, idx, wr_len_o, wr_cmd_o, wr_data_o, rd_word} <= '0;
    end else begin
      if (ack_evt) begin
        rd_word <= rd_data_i;
        rd_ready <= 1'b1;
      end
      if (stop_c) begin
        if (state != BS_IDLE && !rw && idx >= 3'h2) begin
          wr_len_o <= 2'(idx - 3'h2);
          wr_tgl_o <= ~wr_tgl_o;
        end
        state <= BS_IDLE;
        {scl_oe_o, sda_oe_o} <= 2'h0;
      end else if (start_c) begin
        state <= BS_RX;
        {bitcnt, idx, sda_oe_o} <= '0;
      end else begin
        case (state)
          BS_RX: begin
            if (rise && bitcnt != 4'h8) begin
              sh <= {sh[6:0], sda_s2};
              bitcnt <= bitcnt + 4'h1;
            end else if (fall && bitcnt == 4'h8) begin
              case (idx)
                3'h0: rw <= sh[0];
                3'h1: begin
                  wr_cmd_o <= sh;
                  rd_req_tgl_o <= ~rd_req_tgl_o;
                  rd_ready <= 1'b0;
                end
                3'h2: wr_data_o[7:0] <= sh; // Low byte first
                3'h3: wr_data_o[15:8] <= sh;
                default: ;
              endcase
              idx <= (idx == 3'h4) ? idx : idx + 3'h1;
              sda_oe_o <= rx_ack;
              state <= BS_RXACK;
            end
          end
          BS_RXACK: if (fall) begin
            sda_oe_o <= 1'b0;
            bitcnt <= 4'h0;
            tx_hi <= 1'b0;
            if (!sda_oe_o) state <= BS_IDLE;
            else if (idx == 3'h1 && rw) begin
              scl_oe_o <= 1'b1;
              state <= BS_STRETCH;
            end else state <= BS_RX;
          end
          // Stretch SCL until the core domain has answered the read
          BS_STRETCH: if (rd_ready) begin
            scl_oe_o <= 1'b0;
            sda_oe_o <= ~tx_byte[7];
            sh <= {tx_byte[6:0], 1'b0};
            bitcnt <= 4'h1;
            state <= BS_TX;
          end
          BS_TX: if (fall) begin
            if (bitcnt == 4'h8) begin
              sda_oe_o <= 1'b0;
              state <= BS_TXACK;
            end else begin
              sda_oe_o <= ~sh[7];
              sh <= {sh[6:0], 1'b0};
              bitcnt <= bitcnt + 4'h1;
            end
          end
          BS_TXACK: begin
            if (rise) host_ack <= ~sda_s2;
            else if (fall) begin
              if (host_ack && !tx_hi) begin
                tx_hi <= 1'b1; // High byte second
                sda_oe_o <= ~rd_word[15];
                sh <= {rd_word[14:8], 1'b0};
                bitcnt <= 4'h1;
                state <= BS_TX;
              end else state <= BS_IDLE;
            end
          end
          default: state <= BS_IDLE;
        endcase
      end
    end
  end
endmodule
`default_nettype wire

// ==== hw/vcf_regs.sv ====
// Top: vout configuration registers, limits, fault reaction and retry timing
`timescale 1ns/100ps
`default_nettype none
// How it works
// - Clamp the voltage target to the ceiling
// - Ceiling never above 115% of strap voltage
// - Margin-high selects the margin-high target
// - Margin-low selects the margin-low target
// - Ramp target at the programmed transition rate
// - Switching frequency in kHz, 200 to 640
// - Rail count field zero means sixteen
// - Rail position gives phase offset in group
// - Over-voltage when output exceeds its threshold
// - Any over-voltage pulls alert low, sets status
// - Code 10 disables output, then retries
// - Retry count seven retries without limit
// - Other counts retry that many times
// - Retry delay is (field plus one) times 35ms
// - Under-voltage threshold drives fault and power-good
// - Voltages share the vout exponent, compare mantissas
// - Clear-faults command clears status and latch
module vcf_regs #(
  parameter int CYCLES_PER_MS = vcf_pkg::CYC_PER_MS
) (
  input wire logic clock_i,
  input wire logic rstn_i,
  input wire logic link_clk_i,
  input wire logic scl_i,
  output logic scl_o,
  output logic scl_oe_o,
  input wire logic sda_i,
  output logic sda_o,
  output logic sda_oe_o,
  input wire logic [15:0] voltage_strap_pin_i,
  input wire logic [15:0] nominal_vout_i,
  input wire logic [4:0] vout_exponent_i,
  input wire logic [1:0] margin_sel_i,
  input wire logic output_enable_i,
  input wire logic [15:0] meas_vout_i,
  output logic [15:0] vout_target_o,
  output logic output_on_o,
  output logic output_good_flag_o,
  output logic fault_alert_line_o,
  output logic fault_alert_line_oe_o,
  output logic [15:0] load_line_o,
  output logic [9:0] switch_freq_khz_o,
  output logic [4:0] rail_count_o,
  output logic [3:0] rail_position_o,
  output logic [7:0] phase_offset_o
);
  import vcf_pkg::*;

  // Link-side reset and crossing toggles
  logic lrst_s1, link_rstn;
  logic wr_tgl, rd_req_tgl, rd_ack_tgl;
  logic [7:0] wr_cmd;
  logic [15:0] wr_data, rd_data_reg;
  logic [1:0] wr_len;
  logic w_s1, w_s2, w_s3, r_s1, r_s2, r_s3;
  logic [15:0] strap_s1, strap_s2;

  // Register file
  logic [15:0] ceil_reg, mhigh_reg, mlow_reg, ramp_reg, freq_reg;
  logic [15:0] group_reg, ov_lim_reg, uv_lim_reg;
  logic [7:0] react_reg, status_reg;

  // Output stage and fault sequencing
  vcf_fault_state_t fstate;
  logic [2:0] retry_left;
  logic [8:0] wait_ms;
  logic [31:0] ms_cnt;
  logic ms_tick;

  function automatic logic [15:0] ceiling_max(input logic [15:0] strap);
    logic [31:0] p;
    p = (32'(strap) * 32'(CEIL_PCT)) / 32'(PCT_FULL);
    ceiling_max = (p > 32'h0000ffff) ? 16'hffff : p[15:0];
  endfunction

  function automatic logic [15:0] umin(input logic [15:0] a, input logic [15:0] b);
    umin = (a < b) ? a : b;
  endfunction

  // Linear-format V/ms turned into vout mantissa units per ms tick
  function automatic logic [15:0] ramp_step(input logic [15:0] rate, input logic [4:0] vexp);
    logic signed [6:0] sh;
    logic [6:0] neg;
    logic [15:0] st;
    sh = 7'(signed'(rate[15:RATE_EXP_LO])) - 7'(signed'(vexp));
    neg = 7'(-sh);
    if (rate[10:0] == 11'h000 || sh > 7'sh05) st = 16'hffff;
    else if (sh >= 7'sh00) st = 16'({5'h00, rate[10:0]} << sh[2:0]);
    else st = 16'({5'h00, rate[10:0]} >> neg);
    ramp_step = (st == 16'h0000) ? 16'h0001 : st;
  endfunction

  function automatic logic [4:0] rails_of(input logic [3:0] field);
    rails_of = (field == 4'h0) ? 5'h10 : {1'b0, field};
  endfunction

  // Reserved bits of the byte register read as zero
  function automatic logic [15:0] read_word(input logic [7:0] cmd);
    case (cmd)
      CMD_CEILING: read_word = umin(ceil_reg, ceiling_max(strap_s2));
      CMD_MARGIN_HIGH: read_word = mhigh_reg;
      CMD_MARGIN_LOW: read_word = mlow_reg;
      CMD_RAMP_RATE: read_word = ramp_reg;
      CMD_LOAD_LINE: read_word = load_line_o;
      CMD_SWITCH_FREQ: read_word = freq_reg;
      CMD_PHASE_GROUP: read_word = group_reg;
      CMD_OV_THRESH: read_word = ov_lim_reg;
      CMD_OV_REACTION: read_word = {8'h00, react_reg};
      CMD_UV_THRESH: read_word = uv_lim_reg;
      CMD_FAULT_STATUS: read_word = {8'h00, status_reg};
      default: read_word = 16'hffff;
    endcase
  endfunction

  always_ff @(posedge link_clk_i) begin
    lrst_s1 <= rstn_i;
    link_rstn <= lrst_s1;
  end

  vcf_bus_slave u_slave (
    .link_clk_i(link_clk_i),
    .link_rstn_i(link_rstn),
    .scl_i(scl_i),
    .sda_i(sda_i),
    .scl_oe_o(scl_oe_o),
    .sda_oe_o(sda_oe_o),
    .wr_tgl_o(wr_tgl),
    .wr_cmd_o(wr_cmd),
    .wr_data_o(wr_data),
    .wr_len_o(wr_len),
    .rd_req_tgl_o(rd_req_tgl),
    .rd_ack_tgl_i(rd_ack_tgl),
    .rd_data_i(rd_data_reg)
  );

  // Toggle crossings; command and data stay still until the next frame
  always_ff @(posedge clock_i) begin
    {w_s1, w_s2, w_s3} <= {wr_tgl, w_s1, w_s2};
    {r_s1, r_s2, r_s3} <= {rd_req_tgl, r_s1, r_s2};
    strap_s1 <= voltage_strap_pin_i;
    strap_s2 <= strap_s1;
  end

  wire wr_evt = w_s2 ^ w_s3;
  wire rd_evt = r_s2 ^ r_s3;
  wire wr_word = wr_evt && wr_len == LEN_WORD;
  wire wr_byte = wr_evt && wr_len == LEN_BYTE;
  wire clear_faults = wr_evt && wr_len == LEN_SEND && wr_cmd == CMD_CLEAR_FAULTS;

  // Effective ceiling also follows a later drop of the strap
  wire [15:0] ceil_max = ceiling_max(strap_s2);
  wire [15:0] ceil_eff = umin(ceil_reg, ceil_max);

  // Margin and nominal targets are clamped the same way
  wire [15:0] sel_target = (margin_sel_i == MARGIN_HIGH_SEL) ? mhigh_reg :
                           (margin_sel_i == MARGIN_LOW_SEL) ? mlow_reg :
                           nominal_vout_i;
  wire [15:0] setpoint = umin(sel_target, ceil_eff);
  wire [15:0] step = ramp_step(ramp_reg, vout_exponent_i);
  wire [15:0] gap_up = setpoint - vout_target_o;
  wire [15:0] gap_down = vout_target_o - setpoint;
  wire settled = (vout_target_o == setpoint);

  // Common exponent lets thresholds compare as plain mantissas
  wire ov_now = output_on_o && meas_vout_i > ov_lim_reg;
  wire uv_now = output_on_o && settled && meas_vout_i < uv_lim_reg;
  wire [7:0] status_set = {ov_now, 2'h0, uv_now, 4'h0};
  // A fault in the clearing cycle stays set
  wire [7:0] status_next = clear_faults ? status_set : (status_reg | status_set);

  wire [1:0] react_mode = react_reg[REACT_MODE_LO +: 2];
  wire [2:0] retry_cnt = react_reg[RETRY_CNT_LO +: 3];
  wire [2:0] retry_time = react_reg[RETRY_TIME_LO +: 3];
  wire [8:0] retry_ms = 9'((32'(retry_time) + 32'h1) * 32'(RETRY_STEP_MS));
  wire trip = ov_now && react_mode == REACT_DISABLE_RETRY;
  wire may_retry = (retry_cnt == RETRY_FOREVER) || (retry_left != 3'h0);

  wire [3:0] rail_pos = group_reg[RAIL_POS_LO +: 4];
  wire [4:0] rails = rails_of(group_reg[RAILS_LO +: 4]);
  wire [11:0] phase_div = {rail_pos, 8'h00} / {7'h00, rails};

  wire [9:0] freq_raw = (freq_reg > 16'(FREQ_MAX_KHZ)) ? FREQ_MAX_KHZ : freq_reg[9:0];
  wire [9:0] freq_clamped = (freq_raw < FREQ_MIN_KHZ) ? FREQ_MIN_KHZ : freq_raw;

  always_ff @(posedge clock_i) begin
    if (!rstn_i) begin
      {ceil_reg, mhigh_reg, mlow_reg, ramp_reg} <= {4{RST_WORD}};
      {load_line_o, group_reg, ov_lim_reg, uv_lim_reg} <= {4{RST_WORD}};
      freq_reg <= RST_SWITCH_FREQ;
      react_reg <= RST_OV_REACTION;
    end else if (wr_word) begin
      case (wr_cmd)
        CMD_CEILING: ceil_reg <= umin(wr_data, ceil_max);
        CMD_MARGIN_HIGH: mhigh_reg <= wr_data;
        CMD_MARGIN_LOW: mlow_reg <= wr_data;
        CMD_RAMP_RATE: ramp_reg <= wr_data;
        CMD_LOAD_LINE: load_line_o <= wr_data;
        CMD_SWITCH_FREQ: freq_reg <= wr_data;
        CMD_PHASE_GROUP: group_reg <= wr_data;
        CMD_OV_THRESH: ov_lim_reg <= wr_data;
        CMD_UV_THRESH: uv_lim_reg <= wr_data;
        default: ;
      endcase
    end else if (wr_byte && wr_cmd == CMD_OV_REACTION) begin
      react_reg <= wr_data[7:0];
    end
  end

  // Read answers are held until the next request from the link
  always_ff @(posedge clock_i) begin
    if (!rstn_i) begin
      rd_data_reg <= RST_WORD;
      rd_ack_tgl <= 1'b0;
    end else if (rd_evt) begin
      rd_data_reg <= read_word(wr_cmd);
      rd_ack_tgl <= ~rd_ack_tgl;
    end
  end

  // Millisecond time base shared by ramp and retry delay
  always_ff @(posedge clock_i) begin
    if (!rstn_i) begin
      ms_cnt <= 32'h0;
      ms_tick <= 1'b0;
    end else begin
      ms_tick <= (ms_cnt == 32'(CYCLES_PER_MS - 1));
      ms_cnt <= (ms_cnt == 32'(CYCLES_PER_MS - 1)) ? 32'h0 : ms_cnt + 32'h1;
    end
  end

  always_ff @(posedge clock_i) begin
    if (!rstn_i) begin
      vout_target_o <= RST_WORD;
    end else if (ms_tick) begin
      if (setpoint > vout_target_o) begin
        vout_target_o <= (gap_up > step) ? vout_target_o + step : setpoint;
      end else if (setpoint < vout_target_o) begin
        vout_target_o <= (gap_down > step) ? vout_target_o - step : setpoint;
      end
    end
  end

  always_ff @(posedge clock_i) begin
    if (!rstn_i) begin
      status_reg <= 8'h00;
      fault_alert_line_o <= 1'b0;
      fault_alert_line_oe_o <= 1'b0;
      output_good_flag_o <= 1'b0;
    end else begin
      status_reg <= status_next;
      fault_alert_line_o <= 1'b0;
      fault_alert_line_oe_o <= (status_next != 8'h00);
      output_good_flag_o <= output_on_o && !trip && meas_vout_i >= uv_lim_reg;
    end
  end

  // Outputs that only ever drive the open-drain low level
  always_ff @(posedge clock_i) begin
    if (!rstn_i) begin
      scl_o <= 1'b0;
      sda_o <= 1'b0;
    end else begin
      scl_o <= 1'b0;
      sda_o <= 1'b0;
    end
  end

  always_ff @(posedge clock_i) begin
    if (!rstn_i) begin
      switch_freq_khz_o <= FREQ_MIN_KHZ;
      rail_count_o <= 5'h10;
      rail_position_o <= 4'h0;
      phase_offset_o <= 8'h00;
    end else begin
      switch_freq_khz_o <= freq_clamped;
      rail_count_o <= rails;
      rail_position_o <= rail_pos;
      phase_offset_o <= phase_div[7:0];
    end
  end

  // Disabling the output always wins over any retry in flight
  always_ff @(posedge clock_i) begin
    if (!rstn_i) begin
      fstate <= FS_OFF;
      output_on_o <= 1'b0;
      retry_left <= 3'h0;
      wait_ms <= 9'h000;
    end else if (!output_enable_i) begin
      fstate <= FS_OFF;
      output_on_o <= 1'b0;
    end else begin
      case (fstate)
        FS_OFF: begin
          fstate <= FS_RUN;
          output_on_o <= 1'b1;
          retry_left <= retry_cnt;
        end
        FS_RUN: if (trip) begin
          output_on_o <= 1'b0;
          wait_ms <= retry_ms;
          if (retry_cnt == RETRY_NONE || !may_retry) fstate <= FS_LATCH;
          else fstate <= FS_WAIT;
        end
        // Partial first tick makes the wait up to 1 ms longer, never short
        FS_WAIT: if (ms_tick) begin
          if (wait_ms == 9'h000) begin
            fstate <= FS_RUN;
            output_on_o <= 1'b1;
            if (retry_cnt != RETRY_FOREVER) retry_left <= retry_left - 3'h1;
          end else wait_ms <= wait_ms - 9'h001;
        end
        FS_LATCH: if (clear_faults) fstate <= FS_OFF;
        default: fstate <= FS_OFF;
      endcase
    end
  end
endmodule
`default_nettype wire

// ==== tb/vcf_regs_props.sv ====
// Checker: port-level properties of the vout configuration registers
`timescale 1ns/100ps
`default_nettype none
module vcf_regs_props
  import vcf_pkg::*;
#(
  parameter int CYCLES_PER_MS = 20
) (
  input wire logic clock_i,
  input wire logic rstn_i,
  input wire logic scl_o,
  input wire logic sda_o,
  input wire logic [15:0] voltage_strap_pin_i,
  input wire logic output_enable_i,
  input wire logic [15:0] vout_target_o,
  input wire logic output_on_o,
  input wire logic output_good_flag_o,
  input wire logic fault_alert_line_o,
  input wire logic fault_alert_line_oe_o,
  input wire logic [9:0] switch_freq_khz_o,
  input wire logic [4:0] rail_count_o,
  input wire logic [3:0] rail_position_o,
  input wire logic [7:0] phase_offset_o
);
  default clocking cb @(posedge clock_i); endclocking
  default disable iff (!rstn_i);
  property p_freq; switch_freq_khz_o inside {[FREQ_MIN_KHZ:FREQ_MAX_KHZ]}; endproperty
  a_freq: assert property (p_freq) else $error("frequency out of range");
  property p_rails; rail_count_o != 5'h00 && rail_count_o <= 5'h10; endproperty
  a_rails: assert property (p_rails) else $error("rail count out of range");
  property p_phase; ($stable(rail_count_o) && $stable(rail_position_o)) [*3] |->
    phase_offset_o == 8'((12'(rail_position_o) << 8) / 12'(rail_count_o)); endproperty
  a_phase: assert property (p_phase) else $error("phase offset wrong");
  // Ceiling is capped, so no target may pass the strap margin
  property p_ceil; 32'(vout_target_o) * PCT_FULL <= 32'(voltage_strap_pin_i) * CEIL_PCT;
  endproperty
  a_ceil: assert property (p_ceil) else $error("target above strap ceiling");
  property p_fall; $fell(output_on_o) |-> fault_alert_line_oe_o || !$past(output_enable_i)
    || !$past(output_enable_i, 2) || !$past(output_enable_i, 3); endproperty
  a_fall: assert property (p_fall) else $error("output dropped without cause");
  property p_alert; $rose(fault_alert_line_oe_o) |-> $past(output_on_o); endproperty
  a_alert: assert property (p_alert) else $error("alert while output off");
  property p_good; output_good_flag_o |-> output_on_o || $past(output_on_o); endproperty
  a_good: assert property (p_good) else $error("power good while off");
  property p_off; !output_enable_i [*5] |-> !output_on_o; endproperty
  a_off: assert property (p_off) else $error("output on while disabled");
  property p_low; !scl_o && !sda_o && !fault_alert_line_o; endproperty
  a_low: assert property (p_low) else $error("open-drain level not low");
endmodule
bind vcf_regs vcf_regs_props #(.CYCLES_PER_MS(CYCLES_PER_MS)) u_props (
  .clock_i, .rstn_i, .scl_o, .sda_o, .voltage_strap_pin_i, .output_enable_i,
  .vout_target_o, .output_on_o, .output_good_flag_o, .fault_alert_line_o,
  .fault_alert_line_oe_o, .switch_freq_khz_o, .rail_count_o, .rail_position_o,
  .phase_offset_o
);
`default_nettype wire

// ==== tb/vcf_host_model.sv ====
// Bus host model: open-drain master for word, byte and send-byte frames
`timescale 1ns/100ps
`default_nettype none
module vcf_host_model
  import vcf_pkg::*;
#(
  parameter int Q = 2
) (
  input wire logic link_clk_i,
  input wire logic scl_i,
  input wire logic sda_i,
  output logic scl_low_o,
  output logic sda_low_o
);
  int nacks = 0;
  initial begin
    scl_low_o = 1'b0;
    sda_low_o = 1'b0;
  end
  task automatic tk(input int n);
    repeat (n) @(negedge link_clk_i);
  endtask
  // Data moves a cycle after the clock falls; stretch wait is bounded
  task automatic bit_io(input logic b, output logic r);
    int g;
    g = 0;
    tk(1);
    sda_low_o = !b;
    tk(Q);
    scl_low_o = 1'b0;
    while (scl_i !== 1'b1 && g < 4000) begin
      tk(1);
      g++;
    end
    tk(Q);
    r = sda_i;
    tk(Q);
    scl_low_o = 1'b1;
  endtask
  task automatic byte_io(input logic [7:0] tx, input logic ak, output logic [7:0] rx,
                         output logic seen);
    logic r;
    for (int i = 7; i >= 0; i--) begin
      bit_io(tx[i], r);
      rx[i] = r;
    end
    bit_io(ak, r);
    seen = !r;
  endtask
  task automatic put(input logic [7:0] b);
    logic [7:0] d;
    logic s;
    byte_io(b, 1'b1, d, s);
    if (!s) nacks++;
  endtask
  task automatic start(input logic rd);
    sda_low_o = 1'b1;
    tk(Q);
    scl_low_o = 1'b1;
    put({BUS_ADDR, rd});
  endtask
  // Gap after stop keeps frames apart for the slave's resync
  task automatic stop();
    tk(Q);
    sda_low_o = 1'b1;
    tk(Q);
    scl_low_o = 1'b0;
    tk(Q);
    sda_low_o = 1'b0;
    tk(12);
  endtask
  task automatic write(input logic [7:0] cmd, input logic [15:0] d, input int len);
    start(1'b0);
    put(cmd);
    if (len > 0) put(d[7:0]);
    if (len > 1) put(d[15:8]);
    stop();
  endtask
  task automatic read(input logic [7:0] cmd, output logic [15:0] d);
    logic s;
    start(1'b0);
    put(cmd);
    tk(Q);
    sda_low_o = 1'b0;
    tk(Q);
    scl_low_o = 1'b0;
    tk(2 * Q);
    start(1'b1);
    byte_io(8'hff, 1'b0, d[7:0], s);
    byte_io(8'hff, 1'b1, d[15:8], s);
    stop();
  endtask
endmodule
`default_nettype wire

// ==== tb/vcf_regs_tb_top.sv ====
// Testbench: register access, limits and over-voltage reaction
`timescale 1ns/100ps
`default_nettype none
module vcf_regs_tb_top;
  import vcf_pkg::*;
  localparam int CPM = 20;
  logic clock_i = 1'b0;
  logic rstn_i = 1'b0;
  logic link_clk = 1'b0;
  logic [15:0] strap = 16'h1000;
  logic [15:0] nominal = 16'h0c00;
  logic [15:0] meas = 16'h0c00;
  logic [1:0] msel = 2'h0;
  logic oen = 1'b0;
  logic scl_oe, sda_oe, h_scl, h_sda, al_oe, on, good;
  logic [15:0] tgt, droop;
  logic [9:0] freq;
  logic [4:0] rails;
  logic [3:0] pos;
  logic [7:0] phase;
  logic [15:0] fin [3] = '{16'h0064, 16'h02bc, 16'h012c};
  logic [15:0] fex [3] = '{16'h00c8, 16'h0280, 16'h012c};
  logic [15:0] pin [2] = '{16'h0003, 16'h0042};
  logic [15:0] pex [2] = '{16'h1030, 16'h0480};
  wire logic scl_w = !(h_scl | scl_oe);
  wire logic sda_w = !(h_sda | sda_oe);
  int failures = 0;
  int tests_run = 0;
  always #10 clock_i = ~clock_i;
  initial begin
    #37;
    forever #80 link_clk = ~link_clk;
  end
  vcf_regs #(.CYCLES_PER_MS(CPM)) dut (
    .clock_i(clock_i), .rstn_i(rstn_i), .link_clk_i(link_clk), .scl_i(scl_w), .scl_o(),
    .scl_oe_o(scl_oe), .sda_i(sda_w), .sda_o(), .sda_oe_o(sda_oe),
    .voltage_strap_pin_i(strap), .nominal_vout_i(nominal), .vout_exponent_i(5'h00),
    .margin_sel_i(msel), .output_enable_i(oen), .meas_vout_i(meas), .vout_target_o(tgt),
    .output_on_o(on), .output_good_flag_o(good), .fault_alert_line_o(),
    .fault_alert_line_oe_o(al_oe), .load_line_o(droop), .switch_freq_khz_o(freq),
    .rail_count_o(rails), .rail_position_o(pos), .phase_offset_o(phase)
  );
  vcf_host_model #(.Q(2)) host (
    .link_clk_i(link_clk), .scl_i(scl_w), .sda_i(sda_w), .scl_low_o(h_scl), .sda_low_o(h_sda)
  );
  task automatic final_report();
    $display("comparisons %0d mismatches %0d", tests_run, failures);
    if (failures == 0 && tests_run > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    tests_run++;
    if (got !== exp) begin
      failures++;
      $display("ERROR %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(negedge clock_i);
  endtask
  task automatic rchk(input logic [7:0] cmd, input logic [15:0] exp,
                      input logic [15:0] m = 16'hffff);
    logic [15:0] d;
    host.read(cmd, d);
    chk(d & m, exp);
  endtask
  task automatic wr(input logic [7:0] cmd, input logic [15:0] d, input int len = 2);
    host.write(cmd, d, len);
    cyc(4);
  endtask
  task automatic wait_tgt(input logic [15:0] e);
    int n;
    n = 0;
    while (tgt !== e && n < 6000) begin
      cyc(1);
      n++;
    end
    chk(tgt, e);
  endtask
  // Gap is the length of the last off stretch that ended in a restart
  task automatic watch(input int span, output int rises, output int gap);
    int off;
    off = 0;
    rises = 0;
    gap = 0;
    repeat (span) begin
      cyc(1);
      if (on === 1'b1) begin
        if (off > 0) begin
          rises++;
          gap = off;
        end
        off = 0;
      end else off++;
    end
  endtask
  initial begin
    repeat (90000) @(posedge clock_i);
    failures++;
    $display("ERROR %0t: watchdog expired", $time);
    final_report();
  end
  initial begin
    int r, g;
    // Long enough for the link domain's reset copy to see it
    cyc(28);
    rstn_i = 1'b1;
    cyc(2);
    chk(16'(freq), 16'h00c8);
    chk(16'(rails), 16'h0010);
    host.tk(10);
    rchk(CMD_OV_REACTION, 16'h0080, 16'h00ff);
    rchk(8'h55, 16'hffff);
    wr(CMD_LOAD_LINE, 16'h0123);
    chk(droop, 16'h0123);
    rchk(CMD_LOAD_LINE, 16'h0123);
    for (int i = 0; i < 3; i++) begin
      wr(CMD_SWITCH_FREQ, fin[i]);
      chk(16'(freq), fex[i]);
    end
    for (int i = 0; i < 2; i++) begin
      wr(CMD_PHASE_GROUP, pin[i]);
      chk({3'h0, rails, phase}, pex[i]);
      chk(16'(pos), pin[i] & 16'h000f);
    end
    wr(CMD_PHASE_GROUP, 16'h0011, 1);
    chk(16'(pos), 16'h0002);
    wr(CMD_CEILING, 16'h2000);
    rchk(CMD_CEILING, 16'h1266);
    wr(CMD_OV_THRESH, 16'h1800);
    wr(CMD_UV_THRESH, 16'h0a00);
    wr(CMD_MARGIN_HIGH, 16'h1100);
    wr(CMD_MARGIN_LOW, 16'h0e00);
    oen = 1'b1;
    nominal = 16'h1500;
    wait_tgt(16'h1266);
    chk(16'(good), 16'h0001);
    msel = MARGIN_HIGH_SEL;
    wait_tgt(16'h1100);
    msel = MARGIN_LOW_SEL;
    wait_tgt(16'h0e00);
    nominal = 16'h0e08;
    wr(CMD_RAMP_RATE, 16'h0001);
    msel = 2'h0;
    cyc(3 * CPM);
    chk(16'(tgt > 16'h0e00 && tgt < 16'h0e08), 16'h0001);
    wait_tgt(16'h0e08);
    meas = 16'h0900;
    cyc(4);
    chk(16'(good), 16'h0000);
    rchk(CMD_FAULT_STATUS, 16'h0010, 16'h00ff);
    meas = 16'h1800;
    wr(CMD_CLEAR_FAULTS, 16'h0000, 0);
    rchk(CMD_FAULT_STATUS, 16'h0000, 16'h00ff);
    chk({14'h0, al_oe, on}, 16'h0001);
    meas = 16'h1801;
    cyc(3);
    chk({14'h0, al_oe, on}, 16'h0002);
    rchk(CMD_FAULT_STATUS, 16'h0080, 16'h00ff);
    meas = 16'h0e08;
    cyc(50 * CPM);
    chk(16'(on), 16'h0000);
    wr(CMD_CLEAR_FAULTS, 16'h0000, 0);
    chk({14'h0, al_oe, on}, 16'h0001);
    // Retry budget loads when the output comes up from off
    oen = 1'b0;
    wr(CMD_OV_REACTION, 16'h0091, 1);
    oen = 1'b1;
    cyc(4);
    meas = 16'h1801;
    watch(4500, r, g);
    chk(16'(r), 16'h0002);
    chk(16'(g >= 70 * CPM && g <= 71 * CPM), 16'h0001);
    oen = 1'b0;
    meas = 16'h0e08;
    wr(CMD_OV_REACTION, 16'h00b8, 1);
    wr(CMD_CLEAR_FAULTS, 16'h0000, 0);
    oen = 1'b1;
    cyc(4);
    meas = 16'h1801;
    watch(2500, r, g);
    chk(16'(r), 16'h0003);
    oen = 1'b0;
    watch(1500, r, g);
    chk(16'(r), 16'h0000);
    meas = 16'h0e08;
    wr(CMD_OV_REACTION, 16'h0000, 1);
    wr(CMD_CLEAR_FAULTS, 16'h0000, 0);
    oen = 1'b1;
    cyc(4);
    meas = 16'h1801;
    cyc(3);
    chk({14'h0, al_oe, on}, 16'h0003);
    chk(16'(host.nacks), 16'h0000);
    final_report();
  end
endmodule
`default_nettype wire
